// ### pkg/dsp_core_pkg.sv
// Shared constants, operation codes and sequencer states of the datapath.
// Assumes a single 40 MHz clock; nothing here holds logic.
package dsp_core_pkg;

	// ****************************************
	// Widths
	// ****************************************
	localparam int DATA_W = 16;
	localparam int ACC_W  = 32;
	localparam int SH_W   = 5;
	localparam int PORT_W = 3;

	// ****************************************
	// Shift limits and output shift codes
	// ****************************************
	localparam logic [SH_W-1:0] IN_SHIFT_MAX = 5'h10;
	localparam logic [SH_W-1:0] OUT_SH_ONE   = 5'h01;
	localparam logic [SH_W-1:0] OUT_SH_FOUR  = 5'h04;
	localparam logic [SH_W-1:0] OUT_SH_NONE  = 5'h00;

	// ****************************************
	// Port numbers and variants
	// ****************************************
	localparam logic [PORT_W-1:0] PORT_CTRL0  = 3'h0;
	localparam logic [PORT_W-1:0] PORT_CTRL1  = 3'h1;
	localparam logic [PORT_W-1:0] PORT_COPROC = 3'h5;
	localparam logic [DATA_W-1:0] BYTE_MASK   = 16'h00FF;
	localparam int STACK_DEPTH_STD   = 4;
	localparam int STACK_DEPTH_LARGE = 8;
	localparam int PROG_AW_STD   = 12;
	localparam int ROM_WORDS_STD = 4096;

	// ****************************************
	// Operations and sequencer states
	// ****************************************
	typedef enum logic [4:0] {
		OP_NOP  = 5'h00, OP_LAC  = 5'h01, OP_ADD  = 5'h02, OP_SUB  = 5'h03,
		OP_AND  = 5'h04, OP_OR   = 5'h05, OP_XOR  = 5'h06, OP_LACK = 5'h07,
		OP_SACH = 5'h08, OP_SACL = 5'h09, OP_LT   = 5'h0A, OP_MPY  = 5'h0B,
		OP_MPYI = 5'h0C, OP_PAC  = 5'h0D, OP_TBLR = 5'h0E, OP_IN   = 5'h0F,
		OP_OUT  = 5'h10, OP_CALL = 5'h11, OP_RET  = 5'h12, OP_PUSH = 5'h13,
		OP_POP  = 5'h14, OP_POLL = 5'h15
	} op_t;

	typedef enum logic [1:0] {
		PH_IDLE = 2'b00,
		PH_IO1  = 2'b01,
		PH_IO2  = 2'b10
	} phase_t;

endpackage

// ### pkg/stack_if.sv
// Carrier between the datapath and its return stack.
// Assumes both ends share the core clock.
`timescale 1ns/1ps
interface stack_if #(parameter int AW = 12);
	logic          push;
	logic          pop;
	logic [AW-1:0] wdata;
	logic [AW-1:0] top;

	modport owner (input push, input pop, input wdata, output top);
	modport user  (output push, output pop, output wdata, input top);
endinterface

// ### logic/return_stack.sv
// Circular return-address stack; the top entry is held in a register.
// Assumes push and pop are never asked in the same cycle; push wins.
`timescale 1ns/1ps
module return_stack #(
	parameter int DEPTH = 4,
	parameter int AW    = 12
) (
	input wire logic clk,
	input wire logic nrst,
	stack_if.owner   sp
);
	localparam int PW = $clog2(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][AW-1:0] mem;
		logic [PW-1:0]            ptr;
		logic [AW-1:0]            top;
	} stk_t;

	stk_t s_q;
	stk_t s_d;

	// ****************************************
	// Next state
	// ****************************************
	// Overflow overwrites the oldest entry, as a fixed-depth stack must
	always_comb begin
		s_d = s_q;
		if (sp.push) begin
			s_d.mem[s_q.ptr] = sp.wdata;
			s_d.ptr = s_q.ptr + PW'(1);
			s_d.top = sp.wdata;
		end else if (sp.pop) begin
			s_d.ptr = s_q.ptr - PW'(1);
			s_d.top = s_q.mem[PW'(s_q.ptr - PW'(2))];
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign sp.top = s_q.top;

	// ****************************************
	// Checks
	// ****************************************
	AST_PUSH_TOP: assert property (@(posedge clk) disable iff (!nrst)
		sp.push |=> s_q.top == $past(sp.wdata))
		else $error("stack top not the pushed address");
endmodule

// ### logic/dsp_core_datapath.sv
// Core datapath: ALU, accumulator, shifters, multiplier, return stack, I/O.
// Assumes one operation offered per cycle, data RAM outside, pins synchronous.
`timescale 1ns/1ps
module dsp_core_datapath #(
	parameter int AW         = dsp_core_pkg::PROG_AW_STD,
	parameter int ROM_WORDS  = dsp_core_pkg::ROM_WORDS_STD,
	parameter bit LARGE_PROG = 1'b0,
	parameter bit HAS_SERIAL = 1'b0,
	parameter bit HAS_COPROC = 1'b0
) (
	input  wire logic                                  clk,
	input  wire logic                                  nrst,
	input  wire logic                                  op_valid,
	input  wire dsp_core_pkg::op_t                     op_code,
	input  wire logic [dsp_core_pkg::SH_W-1:0]         op_shift,
	input  wire logic [dsp_core_pkg::DATA_W-1:0]       op_imm,
	input  wire logic [dsp_core_pkg::PORT_W-1:0]       op_port,
	input  wire logic [dsp_core_pkg::DATA_W-1:0]       dmem_rdata,
	input  wire logic [dsp_core_pkg::DATA_W-1:0]       pmem_rdata,
	input  wire logic [AW-1:0]                         pc_in,
	input  wire logic [AW-1:0]                         fetch_addr,
	input  wire logic                                  program_memory_select,
	input  wire logic                                  branch_poll_input_n,
	input  wire logic                                  irq_n,
	input  wire logic                                  irq_mask,
	input  wire logic                                  coproc_mode,
	input  wire logic                                  coproc_byte,
	input  wire logic [dsp_core_pkg::DATA_W-1:0]       io_data_in,
	output logic [dsp_core_pkg::ACC_W-1:0]             acc,
	output logic [dsp_core_pkg::ACC_W-1:0]             product,
	output logic [dsp_core_pkg::DATA_W-1:0]            multiplicand,
	output logic [dsp_core_pkg::DATA_W-1:0]            dmem_wdata,
	output logic                                       dmem_we,
	output logic [dsp_core_pkg::PORT_W-1:0]            io_addr,
	output logic                                       io_rd,
	output logic                                       io_wr,
	output logic [dsp_core_pkg::DATA_W-1:0]            io_data_out,
	output logic                                       ctrl0_sel,
	output logic                                       ctrl1_sel,
	output logic                                       coproc_sel,
	output logic                                       busy,
	output logic                                       irq_take,
	output logic                                       poll_low,
	output logic [AW-1:0]                              ret_addr,
	output logic                                       pmem_onchip
);
	import dsp_core_pkg::*;

	typedef struct packed {
		logic [ACC_W-1:0]  acc;
		logic [ACC_W-1:0]  preg;
		logic [DATA_W-1:0] treg;
		logic [DATA_W-1:0] wdata;
		logic              we;
		logic [PORT_W-1:0] port;
		logic              rd;
		logic              wr;
		logic [DATA_W-1:0] dout;
		logic              c0;
		logic              c1;
		logic              cp;
		phase_t            phase;
		logic              bsy;
		logic              itake;
		logic              poll;
		logic [AW-1:0]     ret;
		logic              onchip;
	} core_t;

	core_t st_q;
	core_t st_d;
	logic  go;
	logic  take_irq;

	stack_if #(.AW(AW)) stk ();

	return_stack #(
		.DEPTH (LARGE_PROG ? STACK_DEPTH_LARGE : STACK_DEPTH_STD),
		.AW    (AW)
	) u_stack (
		.clk  (clk),
		.nrst (nrst),
		.sp   (stk.owner)
	);

	// ****************************************
	// Arithmetic helpers
	// ****************************************
	// Clamped at sixteen; larger codes would shift the sign away
	function automatic logic [ACC_W-1:0] in_shift(logic [DATA_W-1:0] d,
		logic [SH_W-1:0] s);
		logic [ACC_W-1:0] x;
		logic [SH_W-1:0]  n;
		x = {{DATA_W{d[DATA_W-1]}}, d};
		n = (s > IN_SHIFT_MAX) ? IN_SHIFT_MAX : s;
		return x << n;
	endfunction

	// Only 0, 1 and 4 exist; other codes store unshifted
	function automatic logic [DATA_W-1:0] out_shift(logic [ACC_W-1:0] a,
		logic [SH_W-1:0] s);
		logic [ACC_W-1:0] x;
		logic [SH_W-1:0]  n;
		n = (s == OUT_SH_ONE || s == OUT_SH_FOUR) ? s : OUT_SH_NONE;
		x = a << n;
		return x[ACC_W-1:DATA_W];
	endfunction

	function automatic logic [ACC_W-1:0] smul(logic [DATA_W-1:0] a,
		logic [DATA_W-1:0] b);
		logic signed [ACC_W-1:0] x;
		logic signed [ACC_W-1:0] y;
		x = $signed({{DATA_W{a[DATA_W-1]}}, a});
		y = $signed({{DATA_W{b[DATA_W-1]}}, b});
		return ACC_W'(x * y);
	endfunction

	// Coprocessor byte mode keeps only the low lane
	function automatic logic [DATA_W-1:0] lane(logic [DATA_W-1:0] d,
		logic [PORT_W-1:0] p);
		if (HAS_COPROC && coproc_mode && coproc_byte && p == PORT_COPROC) begin
			return d & BYTE_MASK;
		end
		return d;
	endfunction

	// ****************************************
	// Next state
	// ****************************************
	assign go       = op_valid && st_q.phase == PH_IDLE;
	// Interrupt only in an idle slot with no operation offered
	assign take_irq = !irq_n && !irq_mask && !op_valid && st_q.phase == PH_IDLE;

	always_comb begin
		st_d       = st_q;
		st_d.we    = 1'b0;
		st_d.itake = 1'b0;
		st_d.poll  = 1'b0;
		stk.push   = 1'b0;
		stk.pop    = 1'b0;
		stk.wdata  = pc_in;
		st_d.onchip = program_memory_select && 32'(fetch_addr) < ROM_WORDS;
		if (take_irq) begin
			st_d.itake = 1'b1;
			stk.push   = 1'b1;
		end
		if (go) begin
			unique case (op_code)
				OP_LAC:  st_d.acc = in_shift(dmem_rdata, op_shift);
				OP_ADD:  st_d.acc = st_q.acc + in_shift(dmem_rdata, op_shift);
				OP_SUB:  st_d.acc = st_q.acc - in_shift(dmem_rdata, op_shift);
				OP_AND:  st_d.acc = st_q.acc & {{DATA_W{1'b0}}, dmem_rdata};
				OP_OR:   st_d.acc = st_q.acc | {{DATA_W{1'b0}}, dmem_rdata};
				OP_XOR:  st_d.acc = st_q.acc ^ {{DATA_W{1'b0}}, dmem_rdata};
				OP_LACK: st_d.acc = {{DATA_W{1'b0}}, op_imm};
				OP_SACH: begin
					st_d.wdata = out_shift(st_q.acc, op_shift);
					st_d.we    = 1'b1;
				end
				OP_SACL: begin
					st_d.wdata = st_q.acc[DATA_W-1:0];
					st_d.we    = 1'b1;
				end
				OP_LT:   st_d.treg = dmem_rdata;
				OP_MPY:  st_d.preg = smul(st_q.treg, dmem_rdata);
				OP_MPYI: st_d.preg = smul(st_q.treg, op_imm);
				OP_PAC:  st_d.acc = st_q.preg;
				OP_TBLR: begin
					st_d.wdata = pmem_rdata;
					st_d.we    = 1'b1;
				end
				OP_IN, OP_OUT: begin
					st_d.phase = PH_IO1;
					st_d.port  = op_port;
					st_d.rd    = op_code == OP_IN;
					st_d.wr    = op_code == OP_OUT;
					st_d.dout  = lane(dmem_rdata, op_port);
					st_d.c0    = HAS_SERIAL && op_port == PORT_CTRL0;
					st_d.c1    = HAS_SERIAL && op_port == PORT_CTRL1;
					st_d.cp    = HAS_COPROC && coproc_mode && op_port == PORT_COPROC;
				end
				OP_CALL: stk.push = 1'b1;
				OP_RET: begin
					st_d.ret = stk.top;
					stk.pop  = 1'b1;
				end
				OP_PUSH: begin
					stk.wdata = AW'(dmem_rdata);
					stk.push  = 1'b1;
				end
				OP_POP: begin
					st_d.wdata = DATA_W'(stk.top);
					st_d.we    = 1'b1;
					stk.pop    = 1'b1;
				end
				OP_POLL: st_d.poll = !branch_poll_input_n;
				default: ;
			endcase
		end
		unique case (st_q.phase)
			PH_IDLE: ;
			PH_IO1:  st_d.phase = PH_IO2;
			PH_IO2: begin
				st_d.phase = PH_IDLE;
				st_d.rd    = 1'b0;
				st_d.wr    = 1'b0;
				st_d.c0    = 1'b0;
				st_d.c1    = 1'b0;
				st_d.cp    = 1'b0;
				if (st_q.rd) begin
					st_d.wdata = lane(io_data_in, st_q.port);
					st_d.we    = 1'b1;
				end
			end
			default: st_d.phase = PH_IDLE;
		endcase
		// Registered so busy leaves a flip-flop, not a decoder
		st_d.bsy = st_d.phase != PH_IDLE;
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign acc          = st_q.acc;
	assign product      = st_q.preg;
	assign multiplicand = st_q.treg;
	assign dmem_wdata   = st_q.wdata;
	assign dmem_we      = st_q.we;
	assign io_addr      = st_q.port;
	assign io_rd        = st_q.rd;
	assign io_wr        = st_q.wr;
	assign io_data_out  = st_q.dout;
	assign ctrl0_sel    = st_q.c0;
	assign ctrl1_sel    = st_q.c1;
	assign coproc_sel   = st_q.cp;
	assign busy         = st_q.bsy;
	assign irq_take     = st_q.itake;
	assign poll_low     = st_q.poll;
	assign ret_addr     = st_q.ret;
	assign pmem_onchip  = st_q.onchip;

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	sequence io_start_s;
		go && (op_code == OP_IN || op_code == OP_OUT);
	endsequence
	sequence io_busy_s;
		busy ##1 busy ##1 !busy;
	endsequence
	sequence in_start_s;
		go && op_code == OP_IN;
	endsequence

	AST_IO_TWO_CYCLES: assert property (io_start_s |=> io_busy_s)
		else $error("io transfer not two cycles");
	AST_IN_CAPTURE: assert property (in_start_s ##2 !coproc_mode |=>
		dmem_we && dmem_wdata == $past(io_data_in))
		else $error("input word not written to data memory");
	AST_PORT_ADDR: assert property (io_start_s |=> io_addr == $past(op_port))
		else $error("io port address wrong");
	AST_MPY: assert property (go && op_code == OP_MPY |=>
		$signed(product) == $signed($past(multiplicand)) * $signed($past(dmem_rdata)))
		else $error("product wrong");
	AST_LAC: assert property (go && op_code == OP_LAC |=>
		acc == in_shift($past(dmem_rdata), $past(op_shift)))
		else $error("input shift wrong");
	AST_SACH: assert property (go && op_code == OP_SACH |=>
		dmem_we && dmem_wdata == out_shift($past(acc), $past(op_shift)))
		else $error("output shift store wrong");
	AST_ADD_WRAP: assert property (go && op_code == OP_ADD |=>
		acc == ACC_W'($past(acc) + in_shift($past(dmem_rdata), $past(op_shift))))
		else $error("add does not wrap");
	AST_EXT_FETCH: assert property (!program_memory_select |=> !pmem_onchip)
		else $error("on-chip rom mapped while select low");
	AST_MASKED: assert property (irq_mask |=> !irq_take)
		else $error("masked interrupt taken");
	AST_TBLR: assert property (go && op_code == OP_TBLR |=>
		dmem_we && dmem_wdata == $past(pmem_rdata))
		else $error("program word not copied");
endmodule

// ### testbench/io_peripheral_model.sv
// Far-side model: eight I/O ports and external program memory.
// Assumes the core holds io_addr, io_rd and io_wr over both I/O cycles.
`timescale 1ns/1ps
module io_peripheral_model #(
	parameter int AW = 12
) (
	input  wire logic          clk,
	input  wire logic [2:0]    io_addr,
	input  wire logic          io_rd,
	input  wire logic          io_wr,
	input  wire logic [15:0]   io_data_out,
	input  wire logic [AW-1:0] fetch_addr,
	output logic      [15:0]   io_data_in,
	output logic      [15:0]   pmem_rdata
);
	// ****
	// Port storage
	// ****
	logic [15:0] wr_q [8];
	logic [7:0]  wv_q = 8'h00;
	logic [15:0] last_q = 16'h5A5A;

	// Released bus shows the inverse, so a stale sample cannot pass
	always_comb begin
		if (!io_rd) begin
			io_data_in = ~last_q;
		end else if (wv_q[io_addr]) begin
			io_data_in = wr_q[io_addr];
		end else begin
			io_data_in = {13'h1528, io_addr};
		end
	end

	always @(posedge clk) begin
		if (io_rd) begin
			last_q <= io_data_in;
		end
		if (io_wr) begin
			wr_q[io_addr] <= io_data_out;
			wv_q[io_addr] <= 1'b1;
		end
	end

	assign pmem_rdata = 16'h6C00 ^ 16'(fetch_addr);
endmodule

// ### testbench/dsp_core_datapath_bench.sv
// Self-checking bench for the datapath and its far-side model.
// Assumes the package, interface and design files are compiled first.
`timescale 1ns/1ps
module dsp_core_datapath_bench;
	import dsp_core_pkg::*;
	// ****
	// Signals
	// ****
	logic        clk = 1'b0;
	logic        nrst = 1'b0;
	logic        v = 1'b0;
	op_t         c = OP_NOP;
	logic [4:0]  sh = 5'h00;
	logic [15:0] d = 16'h0000;
	logic [2:0]  port = 3'h0;
	logic [11:0] pc = 12'h000;
	logic [11:0] fa = 12'h000;
	logic        sel = 1'b0;
	logic        poll_n = 1'b1;
	logic        irq_n = 1'b1;
	logic        mask = 1'b1;
	logic        cmode = 1'b0;
	logic        cbyte = 1'b0;
	logic [15:0] pmem, din, wd, dout, mc;
	logic [31:0] acc, prod;
	logic [11:0] ra;
	logic [2:0]  ioa;
	logic        we, rd, wr, s0, s1, s5, busy, itake, plow, onchip;
	int          fails = 0;
	int          n_compared = 0;

	always #12.5 clk = ~clk;

	dsp_core_datapath #(.ROM_WORDS(2048), .HAS_SERIAL(1'b1), .HAS_COPROC(1'b1)) dut (
		.clk(clk), .nrst(nrst), .op_valid(v), .op_code(c), .op_shift(sh), .op_imm(d),
		.op_port(port), .dmem_rdata(d), .pmem_rdata(pmem), .pc_in(pc), .fetch_addr(fa),
		.program_memory_select(sel), .branch_poll_input_n(poll_n), .irq_n(irq_n),
		.irq_mask(mask), .coproc_mode(cmode), .coproc_byte(cbyte), .io_data_in(din),
		.acc(acc), .product(prod), .multiplicand(mc), .dmem_wdata(wd), .dmem_we(we),
		.io_addr(ioa), .io_rd(rd), .io_wr(wr), .io_data_out(dout), .ctrl0_sel(s0),
		.ctrl1_sel(s1), .coproc_sel(s5), .busy(busy), .irq_take(itake),
		.poll_low(plow), .ret_addr(ra), .pmem_onchip(onchip));

	io_peripheral_model #(.AW(12)) far (.clk(clk), .io_addr(ioa), .io_rd(rd),
		.io_wr(wr), .io_data_out(dout), .fetch_addr(fa), .io_data_in(din),
		.pmem_rdata(pmem));

	// ****
	// Shared tasks
	// ****
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			fails++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask

	// Offered at a falling edge; returns one cycle later with results settled
	task automatic op(input op_t oc, input logic [15:0] dv, input logic [4:0] s = 5'h00);
		v = 1'b1;
		c = oc;
		d = dv;
		sh = s;
		@(negedge clk);
	endtask

	task automatic idle(input int n = 1);
		v = 1'b0;
		repeat (n) @(negedge clk);
	endtask

	task automatic report_and_stop;
		if (fails == 0 && n_compared > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	task automatic io(input op_t oc, input logic [2:0] p, input logic [15:0] dv,
			input logic [15:0] e);
		port = p;
		op(oc, dv);
		chk("busy", 1, busy);
		chk("io_rd", oc == OP_IN, rd);
		chk("io_wr", oc == OP_OUT, wr);
		chk("io_addr", p, ioa);
		chk("ctrl0_sel", p == 3'h0, s0);
		chk("ctrl1_sel", p == 3'h1, s1);
		chk("coproc_sel", p == 3'h5 && cmode, s5);
		idle();
		chk("busy", 1, busy);
		idle();
		chk("busy", 0, busy);
		chk("dmem_we", oc == OP_IN, we);
		if (oc == OP_IN) chk("io_data", e, wd);
		else chk("io_data_out", dv, dout);
	endtask

	// ****
	// Scenarios
	// ****
	task automatic t_shift;
		int sv[5] = '{0, 1, 15, 16, 17};
		for (int i = 0; i < 5; i++) begin
			op(OP_LAC, 16'h8001, 5'(sv[i]));
			chk("lac", 32'hFFFF8001 << (sv[i] > 16 ? 16 : sv[i]), acc);
		end
	endtask

	task automatic t_arith;
		op(OP_LAC, 16'h7FFF, 5'h10);
		chk("acc", 32'h7FFF0000, acc);
		op(OP_ADD, 16'h7FFF, 5'h10);
		chk("acc", 32'hFFFE0000, acc);
		op(OP_ADD, 16'h7FFF, 5'h10);
		chk("acc", 32'h7FFD0000, acc);
		op(OP_SUB, 16'h8000);
		chk("acc", 32'h7FFD8000, acc);
	endtask

	task automatic t_logic;
		op(OP_LACK, 16'h80F0);
		chk("acc", 32'h000080F0, acc);
		op(OP_LAC, 16'h1234, 5'h10);
		op(OP_OR, 16'h00FF);
		chk("acc", 32'h123400FF, acc);
		op(OP_AND, 16'h0F0F);
		chk("acc", 32'h0000000F, acc);
		op(OP_XOR, 16'hFFFF);
		chk("acc", 32'h0000FFF0, acc);
	endtask

	task automatic t_store;
		int xs[4] = '{0, 1, 4, 2};
		logic [15:0] ex[4] = '{16'h1234, 16'h2468, 16'h2345, 16'h1234};
		op(OP_LAC, 16'h1234, 5'h10);
		op(OP_OR, 16'h5678);
		op(OP_SACL, 16'h0000);
		chk("dmem_we", 1, we);
		chk("sacl", 16'h5678, wd);
		for (int i = 0; i < 4; i++) begin
			op(OP_SACH, 16'h0000, 5'(xs[i]));
			chk("sach", ex[i], wd);
		end
		idle();
		chk("dmem_we", 0, we);
	endtask

	task automatic t_mul;
		op(OP_LT, 16'hFFFE);
		chk("multiplicand", 16'hFFFE, mc);
		op(OP_MPY, 16'h0003);
		chk("product", 32'hFFFFFFFA, prod);
		op(OP_MPYI, 16'h8000);
		chk("product", 32'h00010000, prod);
		op(OP_LT, 16'h8000);
		op(OP_MPYI, 16'h8000);
		chk("product", 32'h40000000, prod);
		op(OP_PAC, 16'h0000);
		chk("acc", 32'h40000000, acc);
	endtask

	task automatic t_prog;
		logic [11:0] fx[3] = '{12'h7FF, 12'h800, 12'h3C5};
		for (int i = 0; i < 3; i++) begin
			sel = i < 2;
			fa = fx[i];
			idle(2);
			chk("pmem_onchip", i == 0, onchip);
		end
		op(OP_TBLR, 16'h0000);
		chk("dmem_we", 1, we);
		chk("tblr", 16'h6FC5, wd);
	endtask

	task automatic t_stack;
		for (int i = 1; i <= 5; i++) begin
			pc = 12'(i * 12'h111);
			op(OP_CALL, 16'h0000);
		end
		for (int i = 5; i >= 2; i--) begin
			op(OP_RET, 16'h0000);
			chk("ret_addr", i * 12'h111, ra);
		end
		op(OP_PUSH, 16'h0ABC);
		op(OP_POP, 16'h0000);
		chk("dmem_we", 1, we);
		chk("pop", 16'h0ABC, wd);
	endtask

	task automatic t_irq;
		pc = 12'h7A5;
		for (int m = 1; m >= 0; m--) begin
			mask = (m == 1);
			idle();
			irq_n = 1'b0;
			idle();
			irq_n = 1'b1;
			chk("irq_take", m == 0, itake);
		end
		idle();
		chk("irq_take", 0, itake);
		op(OP_RET, 16'h0000);
		chk("ret_addr", 12'h7A5, ra);
	endtask

	task automatic t_poll;
		for (int i = 0; i < 2; i++) begin
			poll_n = (i == 1);
			op(OP_POLL, 16'h0000);
			chk("poll_low", i == 0, plow);
		end
		idle();
	endtask

	task automatic t_io;
		cmode = 1'b1;
		for (int p = 0; p < 8; p++) io(OP_IN, 3'(p), 16'h0000, {13'h1528, 3'(p)});
		io(OP_OUT, 3'h3, 16'hBEEF, 16'h0000);
		io(OP_IN, 3'h3, 16'h0000, 16'hBEEF);
		cbyte = 1'b1;
		io(OP_IN, 3'h5, 16'h0000, 16'h0045);
		cbyte = 1'b0;
		cmode = 1'b0;
		io(OP_IN, 3'h5, 16'h0000, 16'hA945);
	endtask

	// ****
	// Sequence and watchdog
	// ****
	initial begin
		repeat (16) @(negedge clk);
		nrst = 1'b1;
		chk("acc", 0, acc);
		chk("busy", 0, busy);
		t_shift();
		t_arith();
		t_logic();
		t_store();
		t_mul();
		t_prog();
		t_stack();
		t_irq();
		t_poll();
		t_io();
		report_and_stop();
	end

	// Whole run needs about 110 cycles
	initial begin
		repeat (3000) @(posedge clk);
		fails++;
		report_and_stop();
	end
endmodule
